// File: dv/ebm_fabric_user.sv
// Purpose: fabric user logic driving one port of the embedded memory block
// Assumes: pins held 4 clk_i cycles around each port clock edge
// Notes: port clock stands at its idle level between accesses
`timescale 1ns/10ps
module ebm_fabric_user #(parameter bit FALL = 1'b0) (
   // system
   input wire logic clk_i,
   // pins toward the memory port
   output logic pclk_o,
   output logic ce_n_o,
   output logic we_o,
   output logic oe_o,
   output logic falling_o,
   output ebm_pkg::ebm_addr_type addr_o,
   output ebm_pkg::ebm_word_type din_o
);
   assign falling_o = FALL;
   initial begin
      pclk_o = FALL;
      ce_n_o = 1'b1;
      {we_o, oe_o, addr_o, din_o} = '0;
   end
   task automatic access(input logic ce_n, we, oe, input ebm_pkg::ebm_addr_type a, input ebm_pkg::ebm_word_type d);
      @(negedge clk_i);
      {ce_n_o, we_o, oe_o, addr_o} = {ce_n, we, oe, a};
      din_o = d; // spare bit is plain data, parity left to us
      repeat (4) @(negedge clk_i);
      pclk_o = ~FALL; // active edge only
      repeat (4) @(negedge clk_i);
      pclk_o = FALL;
      repeat (4) @(negedge clk_i);
      ce_n_o = 1'b1;
   endtask
endmodule

// File: dv/ebm_port_ram_test.sv
// Purpose: self-checking bench of the embedded memory block port logic
// Assumes: port a active on rising, port b on falling edges
// Notes: expected words are fixed constants of each scenario
`timescale 1ns/10ps
module ebm_port_ram_test;
   logic clk_i, reset_i, a_clk, a_ce_n, a_we, a_oe, a_fall, b_clk, b_ce_n, b_we, b_oe, b_fall;
   ebm_pkg::ebm_addr_type a_addr, b_addr;
   ebm_pkg::ebm_word_type a_din, b_din, a_rd, a_as, b_rd, b_as;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   ebm_fabric_user #(.FALL(1'b0)) pa (.clk_i(clk_i), .pclk_o(a_clk), .ce_n_o(a_ce_n), .we_o(a_we),
      .oe_o(a_oe), .falling_o(a_fall), .addr_o(a_addr), .din_o(a_din));
   ebm_fabric_user #(.FALL(1'b1)) pb (.clk_i(clk_i), .pclk_o(b_clk), .ce_n_o(b_ce_n), .we_o(b_we),
      .oe_o(b_oe), .falling_o(b_fall), .addr_o(b_addr), .din_o(b_din));
   ebm_port_ram DUT (.clk_i(clk_i), .reset_i(reset_i), .a_clk_i(a_clk), .a_ce_n_i(a_ce_n), .a_we_i(a_we),
      .a_oe_i(a_oe), .a_falling_i(a_fall), .a_addr_i(a_addr), .a_din_i(a_din), .a_rd_data_o(a_rd),
      .a_async_data_o(a_as), .b_clk_i(b_clk), .b_ce_n_i(b_ce_n), .b_we_i(b_we), .b_oe_i(b_oe),
      .b_falling_i(b_fall), .b_addr_i(b_addr), .b_din_i(b_din), .b_rd_data_o(b_rd), .b_async_data_o(b_as));
   task automatic check(input ebm_pkg::ebm_word_type seen, input ebm_pkg::ebm_word_type exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic t_write_read;
      pa.access(1'b0, 1'b1, 1'b1, 9'h003, 9'h1A5);
      check(a_as, 9'h1A5);
      pa.access(1'b0, 1'b0, 1'b0, 9'h003, 9'h000);
      check(a_rd, 9'h1A5);
      $display("write then read done");
   endtask
   task automatic t_gate_and_oe;
      pa.access(1'b1, 1'b1, 1'b1, 9'h003, 9'h0FF);
      check(a_as, 9'h1A5);
      pa.access(1'b0, 1'b1, 1'b1, 9'h010, 9'h02A);
      pa.access(1'b1, 1'b0, 1'b0, 9'h010, 9'h000);
      check(a_rd, 9'h1A5);
      check(a_as, 9'h02A);
      pa.access(1'b0, 1'b1, 1'b0, 9'h010, 9'h155);
      check(a_as, 9'h02A);
      check(a_rd, 9'h1A5);
      $display("gate and output enable done");
   endtask
   task automatic t_port_b;
      pb.access(1'b0, 1'b1, 1'b1, 9'h1FF, 9'h1C3);
      pa.access(1'b0, 1'b0, 1'b0, 9'h1FF, 9'h000);
      check(a_rd, 9'h1C3);
      pb.access(1'b0, 1'b0, 1'b0, 9'h003, 9'h000);
      check(b_rd, 9'h1A5);
      check(b_as, 9'h1A5);
      $display("second port done");
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      reset_i = 1'b1;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      check(a_rd, `EBM_WORD_RESET);
      reset_i = 1'b0;
      t_write_read();
      t_gate_and_oe();
      t_port_b();
      close_out();
   end
endmodule

// File: include/ebm_cfg.svh
// Purpose: constants of the embedded memory block port logic
// Assumes: word layout of 512 x 9 (8 data bits plus 1 spare bit)
// Notes: all timing is in cycles of clk_i
`ifndef EBM_CFG_SVH
`define EBM_CFG_SVH

`define EBM_WIDTH 9
`define EBM_ADDR_W 9
`define EBM_DEPTH 512
`define EBM_PORTS 2
`define EBM_CAPACITY_MIN 4600
`define EBM_WORD_RESET 9'h000

`endif

// File: include/ebm_pkg.sv
// Purpose: shared types of the embedded memory block port logic
// Assumes: ebm_cfg.svh constants
// Notes: no parity is generated or checked inside the block
`include "ebm_cfg.svh"

package ebm_pkg;
   typedef logic [`EBM_WIDTH-1:0] ebm_word_type;
   typedef logic [`EBM_ADDR_W-1:0] ebm_addr_type;
   // one fabric port sampled into the clk_i domain
   typedef struct packed {
      logic clk;
      logic ce_n;
      logic we;
      logic oe;
      logic falling;
      ebm_addr_type addr;
      ebm_word_type din;
   } ebm_pins_type;
endpackage

// File: logic/ebm_port_ram.sv
// Purpose: dual-port embedded_memory_block with clocked and unclocked reads
// Assumes: fabric port pins are asynchronous to clk_i and change slower than clk_i/2
// Notes: port clock edges are detected after a two-flop synchroniser
`timescale 1ns/10ps
`include "ebm_cfg.svh"

module ebm_port_ram (
   // system
   input wire logic clk_i,
   input wire logic reset_i,
   // port a pins from fabric
   input wire logic a_clk_i,
   input wire logic a_ce_n_i,
   input wire logic a_we_i,
   input wire logic a_oe_i,
   input wire logic a_falling_i,
   input wire logic [`EBM_ADDR_W-1:0] a_addr_i,
   input wire logic [`EBM_WIDTH-1:0] a_din_i,
   // port a data
   output logic [`EBM_WIDTH-1:0] a_rd_data_o,
   output logic [`EBM_WIDTH-1:0] a_async_data_o,
   // port b pins from fabric
   input wire logic b_clk_i,
   input wire logic b_ce_n_i,
   input wire logic b_we_i,
   input wire logic b_oe_i,
   input wire logic b_falling_i,
   input wire logic [`EBM_ADDR_W-1:0] b_addr_i,
   input wire logic [`EBM_WIDTH-1:0] b_din_i,
   // port b data
   output logic [`EBM_WIDTH-1:0] b_rd_data_o,
   output logic [`EBM_WIDTH-1:0] b_async_data_o
);

   ebm_pkg::ebm_pins_type pins_raw [`EBM_PORTS];
   ebm_pkg::ebm_pins_type sync1_reg [`EBM_PORTS];
   ebm_pkg::ebm_pins_type sync2_reg [`EBM_PORTS];
   logic clk_prev_reg [`EBM_PORTS];
   ebm_pkg::ebm_pins_type sync1_next [`EBM_PORTS];
   ebm_pkg::ebm_pins_type sync2_next [`EBM_PORTS];
   logic clk_prev_next [`EBM_PORTS];
   logic edge_act [`EBM_PORTS];
   logic rd_fire [`EBM_PORTS];
   logic wr_fire [`EBM_PORTS];
   ebm_pkg::ebm_word_type rd_reg [`EBM_PORTS];
   ebm_pkg::ebm_word_type rd_next [`EBM_PORTS];
   ebm_pkg::ebm_word_type async_word [`EBM_PORTS];
   // no reset on the array: contents survive reset like a real block
   ebm_pkg::ebm_word_type mem [`EBM_DEPTH];

   // active edge of a sampled port clock for the chosen polarity
   function automatic logic ebm_edge(input logic now, input logic prev, input logic falling);
      ebm_edge = falling ? (prev & ~now) : (now & ~prev);
   endfunction

   always_comb begin
      pins_raw[0] = '{a_clk_i, a_ce_n_i, a_we_i, a_oe_i, a_falling_i, a_addr_i, a_din_i};
      pins_raw[1] = '{b_clk_i, b_ce_n_i, b_we_i, b_oe_i, b_falling_i, b_addr_i, b_din_i};
   end

   // address, data and controls share the clock's two stages so they stay aligned to it
   always_comb begin
      for (int p = 0; p < `EBM_PORTS; p++) begin
         if (reset_i) begin
            sync1_next[p] = '0;
            sync2_next[p] = '0;
            clk_prev_next[p] = 1'b0;
         end else begin
            sync1_next[p] = pins_raw[p];
            sync2_next[p] = sync1_reg[p];
            clk_prev_next[p] = sync2_reg[p].clk;
         end
      end
   end

   // only the second stage feeds logic; the first may still be settling
   always_ff @(posedge clk_i) begin
      for (int p = 0; p < `EBM_PORTS; p++) begin
         sync1_reg[p] <= sync1_next[p];
         sync2_reg[p] <= sync2_next[p];
         clk_prev_reg[p] <= clk_prev_next[p];
      end
   end

   always_comb begin
      for (int p = 0; p < `EBM_PORTS; p++) begin
         edge_act[p] = ebm_edge(sync2_reg[p].clk, clk_prev_reg[p], sync2_reg[p].falling);
         rd_fire[p] = edge_act[p] & ~sync2_reg[p].ce_n & ~sync2_reg[p].we;
         wr_fire[p] = edge_act[p] & ~sync2_reg[p].ce_n & sync2_reg[p].we & sync2_reg[p].oe;
         async_word[p] = mem[sync2_reg[p].addr];
         rd_next[p] = rd_fire[p] ? async_word[p] : rd_reg[p];
      end
   end

   always_ff @(posedge clk_i) begin
      for (int p = 0; p < `EBM_PORTS; p++) begin
         if (reset_i) begin
            rd_reg[p] <= `EBM_WORD_RESET;
         end else begin
            rd_reg[p] <= rd_next[p];
         end
      end
   end

   // port b wins a same-address collision; a read racing a write sees the old word
   always_ff @(posedge clk_i) begin
      for (int p = 0; p < `EBM_PORTS; p++) begin
         if (wr_fire[p]) begin
            mem[sync2_reg[p].addr] <= sync2_reg[p].din;
         end
      end
   end

   assign a_rd_data_o = rd_reg[0];
   assign b_rd_data_o = rd_reg[1];
   // unclocked path is combinational by nature; it settles within a cycle
   assign a_async_data_o = async_word[0];
   assign b_async_data_o = async_word[1];

   chk_capacity_size: assert property (@(posedge clk_i)
      (`EBM_DEPTH * `EBM_WIDTH) >= `EBM_CAPACITY_MIN)
      else $error("memory smaller than required");

   // same-address collision: the later port in the write loop must win
   chk_collision_b_wins: assert property (@(posedge clk_i) disable iff (reset_i)
      (wr_fire[0] && wr_fire[1] && sync2_reg[0].addr == sync2_reg[1].addr) ##1
      $stable(sync2_reg[0].addr) |-> async_word[0] == $past(sync2_reg[1].din))
      else $error("port b did not win write collision");

   for (genvar g = 0; g < `EBM_PORTS; g++) begin : g_chk
      chk_gate_blocks_read: assert property (@(posedge clk_i) disable iff (reset_i)
         (edge_act[g] && sync2_reg[g].ce_n) |=> $stable(rd_reg[g]))
         else $error("read data changed with clock gate high");

      chk_gate_blocks_write: assert property (@(posedge clk_i) disable iff (reset_i)
         (edge_act[g] && sync2_reg[g].ce_n && !wr_fire[1-g]) ##1 $stable(sync2_reg[g].addr)
         |-> $stable(async_word[g]))
         else $error("memory changed with clock gate high");

      chk_read_loads_word: assert property (@(posedge clk_i) disable iff (reset_i)
         rd_fire[g] |=> rd_reg[g] == $past(async_word[g]))
         else $error("clocked read did not load addressed word");

      chk_read_hold: assert property (@(posedge clk_i) disable iff (reset_i)
         !rd_fire[g] |=> rd_reg[g] == $past(rd_reg[g]))
         else $error("read data moved without enabled read edge");

      chk_edge_polarity: assert property (@(posedge clk_i) disable iff (reset_i)
         (sync2_reg[g].clk != clk_prev_reg[g]) |->
         (edge_act[g] == (sync2_reg[g].falling ? clk_prev_reg[g] : sync2_reg[g].clk)))
         else $error("port edge taken at wrong polarity");

      chk_write_stores: assert property (@(posedge clk_i) disable iff (reset_i)
         (wr_fire[g] && !(wr_fire[1-g] && g == 0)) ##1 $stable(sync2_reg[g].addr)
         |-> async_word[g] == $past(sync2_reg[g].din))
         else $error("written word not stored");

      chk_write_needs_oe: assert property (@(posedge clk_i) disable iff (reset_i)
         (edge_act[g] && sync2_reg[g].we && !sync2_reg[g].oe && !wr_fire[1-g]) ##1
         $stable(sync2_reg[g].addr) |-> $stable(async_word[g]))
         else $error("write happened without output enable");

      chk_async_follows: assert property (@(posedge clk_i) disable iff (reset_i)
         (!wr_fire[0] && !wr_fire[1] && $changed(sync2_reg[g].addr)) |=>
         ##0 (sync2_reg[g].addr == $past(sync2_reg[g].addr)) |-> async_word[g] == $past(async_word[g]))
         else $error("unclocked read unstable at fixed address");

      // read data must leave reset at its defined word
      chk_reset_clears_read: assert property (@(posedge clk_i)
         reset_i |=> rd_reg[g] == `EBM_WORD_RESET)
         else $error("read data not cleared by reset");

      chk_no_edge_holds: assert property (@(posedge clk_i) disable iff (reset_i)
         !edge_act[g] |=> $stable(rd_reg[g]))
         else $error("read data moved without a port edge");

      chk_write_sel_blocks: assert property (@(posedge clk_i) disable iff (reset_i)
         (edge_act[g] && sync2_reg[g].we) |=> $stable(rd_reg[g]))
         else $error("read data loaded during a write");

      chk_gate_no_fire: assert property (@(posedge clk_i) disable iff (reset_i)
         sync2_reg[g].ce_n |-> (!rd_fire[g] && !wr_fire[g]))
         else $error("access fired with clock gate high");

      chk_edge_needs_toggle: assert property (@(posedge clk_i) disable iff (reset_i)
         edge_act[g] |-> sync2_reg[g].clk != clk_prev_reg[g])
         else $error("edge seen without port clock change");

      chk_edge_single_cycle: assert property (@(posedge clk_i) disable iff (reset_i)
         edge_act[g] |=> !edge_act[g])
         else $error("one port edge taken twice");

      // only a loaded read may change the clocked output
      chk_read_only_on_fire: assert property (@(posedge clk_i) disable iff (reset_i)
         $changed(rd_reg[g]) |-> $past(rd_fire[g]))
         else $error("read data changed without a read");

      // a read leaves the array alone, data pins are ignored
      chk_read_keeps_mem: assert property (@(posedge clk_i) disable iff (reset_i)
         (rd_fire[g] && !wr_fire[1-g]) ##1 $stable(sync2_reg[g].addr) |-> $stable(async_word[g]))
         else $error("clocked read altered memory");

      cov_clocked_read: cover property (@(posedge clk_i) disable iff (reset_i) rd_fire[g]);
      cov_clocked_write: cover property (@(posedge clk_i) disable iff (reset_i) wr_fire[g] ##[1:40] rd_fire[g]);
      cov_gated_edge: cover property (@(posedge clk_i) disable iff (reset_i) edge_act[g] && sync2_reg[g].ce_n);
      cov_write_no_oe: cover property (@(posedge clk_i) disable iff (reset_i)
         edge_act[g] && sync2_reg[g].we && !sync2_reg[g].oe && !sync2_reg[g].ce_n);
   end

endmodule
